// ==== include/bcmc_pkg.sv ====
// Package of constants and types for the battery conditioning and mode control block
package bcmc_pkg;

	// ****************************************************
	// Conditioning battery-select codes
	// ****************************************************
	localparam logic [3:0] SEL_AUTO = 4'h0;
	localparam logic [3:0] SEL_BAT1 = 4'h1;
	localparam logic [3:0] SEL_BAT2 = 4'h2;
	localparam logic [3:0] SEL_RST  = 4'h0;

	// ****************************************************
	// Powered-by report codes
	// ****************************************************
	localparam logic [3:0] PWR_NONE = 4'h0;
	localparam logic [3:0] PWR_BAT1 = 4'h1;
	localparam logic [3:0] PWR_BAT2 = 4'h2;
	localparam logic [3:0] PWR_BOTH = 4'h3;

	// ****************************************************
	// Operating behaviours decoded from strap and supply sense
	// ****************************************************
	typedef enum logic [1:0]
	{
		MODE_STANDALONE = 2'h0,
		MODE_INHIBIT    = 2'h1,
		MODE_HOST       = 2'h3,
		MODE_AUTONOMOUS = 2'h2
	} bcmc_mode_t;

	// ****************************************************
	// Conditioning sequence
	// ****************************************************
	typedef enum logic [1:0]
	{
		CS_IDLE   = 2'h0,
		CS_DISCH  = 2'h1,
		CS_CHARGE = 2'h3
	} bcmc_cstate_t;

endpackage

// ==== core/bcmc_core.sv ====
// Conditioning selection, discharge control and mode-pin decode for a dual battery manager
`timescale 1ns/100ps
// ****************************************************
// Operation
// - Code 0001b selects battery 1 if requesting
// - Code 0010b selects battery 2 if requesting
// - Code 0000b clears selection; reset default
// - Select writes ignored during a discharge
// - Cache request flags; raise pending status
// - Automatic choice follows cached request flag
// - Both requesting automatically: pick battery 1
// - No requester, automatic choice: conditioning never starts
// - Discharge selected battery while active bit high
// - Freeze cached flags while active bit set
// - Clear active on adapter, fault, alarms, write
// - Removed battery ends; other requester takes over
// - After discharge ends, request a charge cycle
// - Standalone: data pin shows battery 2 status
// - Standalone: alert pin shows battery 1 status
// - Standalone: clock pin sets the blink rate
// - Strap low, supply high: inhibit charging
// - Strap high, supply low: ignore host pins
// - Strap high, supply high: all normal
// - Only conditioned battery powers the system
// ****************************************************
module bcmc_core
	import bcmc_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic       blink_clk,
	input  wire logic       sel_wr,
	input  wire logic [3:0] sel_wdata,
	input  wire logic       active_wr,
	input  wire logic       active_wdata,
	input  wire logic [1:0] cond_flag,
	input  wire logic [1:0] bat_present,
	input  wire logic [1:0] stop_discharge_alarm,
	input  wire logic [1:0] empty_alarm,
	input  wire logic [1:0] bat_charging,
	input  wire logic       adapter_detected,
	input  wire logic       power_fault,
	input  wire logic       mode_strap,
	input  wire logic       host_bus_supply_sense,
	output logic [3:0]      conditioning_battery_select,
	output logic            cond_active,
	output logic            cond_pending,
	output logic [1:0]      discharge_en,
	output logic [3:0]      powered_by,
	output logic            charge_request,
	output logic            charge_blocked,
	output logic            charge_allowed,
	output logic            host_pins_ignored,
	output logic            host_data_o,
	output logic            host_data_oe_n,
	output logic            alert_o,
	output logic            alert_oe_n
);
	// ****************************************************
	// Link clock domain: blink clock divides by two
	// ****************************************************
	// Reset reaches this domain through two flops, so the rate clock must
	// give a few edges while reset is held or the toggle starts undefined
	logic [1:0] link_rst_r;
	logic       blink_tgl_r;

	always_ff @(posedge blink_clk)
	begin
		link_rst_r <= {link_rst_r[0], sys_rst};
		if (link_rst_r[1])
			blink_tgl_r <= 1'b0;
		else
			blink_tgl_r <= ~blink_tgl_r;
	end

	// ****************************************************
	// State of the system clock domain
	// ****************************************************
	typedef struct packed
	{
		logic [1:0]   mode_s1;
		logic [1:0]   mode_s2;
		logic         tgl_s1;
		logic         tgl_s2;
		logic         tgl_d;
		logic         blink;
		logic [3:0]   sel;
		logic [1:0]   flag_cache;
		logic [1:0]   cur;
		bcmc_cstate_t cst;
		logic         active;
		logic         chg_req;
		logic         pend;
		logic         blocked;
		logic         allowed;
		logic         ign;
		logic         data_o;
		logic         alert_o;
		logic         data_oe_n;
		logic         alert_oe_n;
		logic [3:0]   pby;
	} bcmc_state_t;

	bcmc_state_t st_r;
	bcmc_state_t st_nxt;
	bcmc_mode_t  mode;
	logic        blink_edge;
	logic [1:0]  auto_pick;
	logic [1:0]  want;
	logic        end_run;
	logic [1:0]  other;

	assign mode = bcmc_mode_t'(st_r.mode_s2);
	// Blink input holds no edge when tied high, so the output sits steady
	assign blink_edge = st_r.tgl_s2 ^ st_r.tgl_d;

	always_comb
	begin
		st_nxt = st_r;
		auto_pick = 2'h0;
		want = 2'h0;
		end_run = 1'b0;
		other = 2'h0;
		st_nxt.mode_s1 = {mode_strap, host_bus_supply_sense};
		st_nxt.mode_s2 = st_r.mode_s1;
		// Charging stays allowed in every behaviour but the hardware inhibit
		st_nxt.blocked = (st_nxt.mode_s2 == MODE_INHIBIT);
		st_nxt.allowed = (st_nxt.mode_s2 != MODE_INHIBIT);
		st_nxt.ign = (st_nxt.mode_s2 == MODE_AUTONOMOUS);
		st_nxt.tgl_s1 = blink_tgl_r;
		st_nxt.tgl_s2 = st_r.tgl_s1;
		st_nxt.tgl_d = st_r.tgl_s2;
		if (blink_edge)
			st_nxt.blink = ~st_r.blink;
		if (!st_r.active)
			st_nxt.flag_cache = cond_flag;
		st_nxt.pend = |st_nxt.flag_cache;
		// Select field update, only outside a discharge
		if (sel_wr && !st_r.active)
		begin
			if (sel_wdata == SEL_BAT1 && st_r.flag_cache[0])
				st_nxt.sel = SEL_BAT1;
			else if (sel_wdata == SEL_BAT2 && st_r.flag_cache[1])
				st_nxt.sel = SEL_BAT2;
			else if (sel_wdata == SEL_AUTO)
				st_nxt.sel = SEL_AUTO;
		end
		// Battery 1 wins a tie in the automatic choice
		if (st_r.flag_cache[0])
			auto_pick = 2'h1;
		else if (st_r.flag_cache[1])
			auto_pick = 2'h2;
		if (st_r.sel == SEL_BAT1)
			want = 2'h1;
		else if (st_r.sel == SEL_BAT2)
			want = 2'h2;
		else
			want = auto_pick;
		other = ~st_r.cur;
		case (st_r.cst)
			CS_IDLE:
			begin
				// A start request with no requester under automatic choice is dropped
				if (active_wr && active_wdata && want != 2'h0 && adapter_detected)
				begin
					st_nxt.active = 1'b1;
					st_nxt.cur = want;
					st_nxt.cst = CS_DISCH;
				end
			end
			CS_DISCH:
			begin
				if ((active_wr && !active_wdata) || !adapter_detected || power_fault)
					end_run = 1'b1;
				else if (|(st_r.cur & (stop_discharge_alarm | empty_alarm)))
					end_run = 1'b1;
				else if (!(|(st_r.cur & bat_present)))
				begin
					// Hand over to the other pack if it still asks
					if (|(other & st_r.flag_cache & bat_present))
						st_nxt.cur = other;
					else
						end_run = 1'b1;
				end
				if (end_run)
				begin
					st_nxt.active = 1'b0;
					st_nxt.cur = 2'h0;
					st_nxt.cst = CS_CHARGE;
				end
			end
			CS_CHARGE:
			begin
				st_nxt.chg_req = 1'b1;
				st_nxt.cst = CS_IDLE;
			end
			default:
				st_nxt.cst = CS_IDLE;
		endcase
		if (st_r.cst != CS_CHARGE)
			st_nxt.chg_req = 1'b0;
		// Power source report follows the conditioned pack
		st_nxt.pby = (st_nxt.cur == 2'h1) ? PWR_BAT1 :
			(st_nxt.cur == 2'h2) ? PWR_BAT2 : PWR_NONE;
		st_nxt.data_oe_n = 1'b1;
		st_nxt.alert_oe_n = 1'b1;
		st_nxt.data_o = 1'b1;
		st_nxt.alert_o = 1'b1;
		if (mode == MODE_STANDALONE)
		begin
			st_nxt.data_oe_n = 1'b0;
			st_nxt.alert_oe_n = 1'b0;
			if (bat_charging[1])
				st_nxt.data_o = 1'b0;
			else if (adapter_detected && bat_present[1])
				st_nxt.data_o = st_nxt.blink;
			if (bat_charging[0])
				st_nxt.alert_o = 1'b0;
			else if (adapter_detected && bat_present[0])
				st_nxt.alert_o = st_nxt.blink;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (sys_rst)
		begin
			st_r <= '0;
			st_r.sel <= SEL_RST;
			st_r.cst <= CS_IDLE;
			st_r.data_o <= 1'b1;
			st_r.alert_o <= 1'b1;
			st_r.data_oe_n <= 1'b1;
			st_r.alert_oe_n <= 1'b1;
			st_r.mode_s1 <= MODE_HOST;
			st_r.mode_s2 <= MODE_HOST;
			st_r.allowed <= 1'b1;
		end
		else
			st_r <= st_nxt;
	end

	// ****************************************************
	// Outputs, all from state flip-flops
	// ****************************************************
	assign conditioning_battery_select = st_r.sel;
	assign cond_active = st_r.active;
	assign cond_pending = st_r.pend;
	assign discharge_en = st_r.cur;
	assign powered_by = st_r.pby;
	assign charge_request = st_r.chg_req;
	assign charge_blocked = st_r.blocked;
	assign charge_allowed = st_r.allowed;
	assign host_pins_ignored = st_r.ign;
	assign host_data_o = st_r.data_o;
	assign host_data_oe_n = st_r.data_oe_n;
	assign alert_o = st_r.alert_o;
	assign alert_oe_n = st_r.alert_oe_n;

	// ****************************************************
	// Checks
	// ****************************************************
	AST_SEL_FROZEN: assert property (@(posedge mclk) disable iff (sys_rst)
		st_r.active && $past(st_r.active) |-> $stable(st_r.sel))
		else $error("select changed during discharge");
	AST_NO_START: assert property (@(posedge mclk) disable iff (sys_rst)
		st_r.cst == CS_IDLE && st_r.flag_cache == 2'h0 && st_r.sel == SEL_AUTO |=> !st_r.active)
		else $error("discharge started with no requester");
	AST_TIE_BAT1: assert property (@(posedge mclk) disable iff (sys_rst)
		st_r.cst == CS_IDLE && st_r.sel == SEL_AUTO && st_r.flag_cache == 2'h3
		&& active_wr && active_wdata && adapter_detected |=> discharge_en == 2'h1)
		else $error("tie not resolved to battery 1");
	AST_CACHE_FREEZE: assert property (@(posedge mclk) disable iff (sys_rst)
		$past(st_r.active) && st_r.active |-> $stable(st_r.flag_cache))
		else $error("cache updated while active");
	AST_FAULT_END: assert property (@(posedge mclk) disable iff (sys_rst)
		st_r.active && power_fault |=> !st_r.active ##1 charge_request)
		else $error("fault did not end discharge and request charge");
	AST_INHIBIT: assert property (@(posedge mclk) disable iff (sys_rst)
		mode == MODE_INHIBIT |-> charge_blocked && !charge_allowed)
		else $error("inhibit mode not reported");
	AST_STANDALONE_DRV: assert property (@(posedge mclk) disable iff (sys_rst)
		mode == MODE_STANDALONE && bat_charging[1] |=> !host_data_oe_n && !host_data_o)
		else $error("battery 2 charging not shown low");
	AST_PWR_BY: assert property (@(posedge mclk) disable iff (sys_rst)
		discharge_en == 2'h1 |-> powered_by == PWR_BAT1)
		else $error("powered-by mismatch");
	AST_PWR_BAT2: assert property (@(posedge mclk) disable iff (sys_rst)
		discharge_en == 2'h2 |-> powered_by == PWR_BAT2)
		else $error("powered-by mismatch for battery 2");
	AST_SEL_BAT1: assert property (@(posedge mclk) disable iff (sys_rst)
		!st_r.active && sel_wr && sel_wdata == SEL_BAT1 && st_r.flag_cache[0]
		|=> st_r.sel == SEL_BAT1)
		else $error("battery 1 select not taken");
	AST_SEL_REFUSE1: assert property (@(posedge mclk) disable iff (sys_rst)
		!st_r.active && sel_wr && sel_wdata == SEL_BAT1 && !st_r.flag_cache[0]
		|=> $stable(st_r.sel))
		else $error("battery 1 select taken without a request");
	AST_SEL_BAT2: assert property (@(posedge mclk) disable iff (sys_rst)
		!st_r.active && sel_wr && sel_wdata == SEL_BAT2 && st_r.flag_cache[1]
		|=> st_r.sel == SEL_BAT2)
		else $error("battery 2 select not taken");
	AST_SEL_REFUSE2: assert property (@(posedge mclk) disable iff (sys_rst)
		!st_r.active && sel_wr && sel_wdata == SEL_BAT2 && !st_r.flag_cache[1]
		|=> $stable(st_r.sel))
		else $error("battery 2 select taken without a request");
	AST_SEL_CLEAR: assert property (@(posedge mclk) disable iff (sys_rst)
		!st_r.active && sel_wr && sel_wdata == SEL_AUTO |=> st_r.sel == SEL_AUTO)
		else $error("select field not cleared");
	AST_SEL_RESET: assert property (@(posedge mclk)
		sys_rst |=> st_r.sel == SEL_RST)
		else $error("select field not at its reset default");
	AST_PEND_FLAG: assert property (@(posedge mclk) disable iff (sys_rst)
		cond_pending == (|st_r.flag_cache))
		else $error("pending status does not match the cached flags");
	AST_CACHE_FOLLOW: assert property (@(posedge mclk) disable iff (sys_rst)
		!st_r.active |=> st_r.flag_cache == $past(cond_flag))
		else $error("cached flags not refreshed while idle");
	AST_AUTO_ONE: assert property (@(posedge mclk) disable iff (sys_rst)
		st_r.cst == CS_IDLE && st_r.sel == SEL_AUTO && st_r.flag_cache == 2'h2
		&& active_wr && active_wdata && adapter_detected |=> discharge_en == 2'h2)
		else $error("automatic choice missed the only requester");
	AST_RUN_HOLDS: assert property (@(posedge mclk) disable iff (sys_rst)
		st_r.active && !active_wr && !power_fault && adapter_detected
		&& !(|(discharge_en & (stop_discharge_alarm | empty_alarm)))
		&& (|(discharge_en & bat_present)) |=> st_r.active && $stable(discharge_en))
		else $error("discharge did not hold on the selected battery");
	AST_HANDOVER: assert property (@(posedge mclk) disable iff (sys_rst)
		st_r.active && !active_wr && !power_fault && adapter_detected
		&& !(|(discharge_en & (stop_discharge_alarm | empty_alarm)))
		&& !(|(discharge_en & bat_present))
		&& (|(~discharge_en & st_r.flag_cache & bat_present))
		|=> st_r.active && discharge_en == ~$past(discharge_en))
		else $error("removed pack not handed over to the other requester");
	AST_REMOVE_END: assert property (@(posedge mclk) disable iff (sys_rst)
		st_r.active && !active_wr && !power_fault && adapter_detected
		&& !(|(discharge_en & (stop_discharge_alarm | empty_alarm)))
		&& !(|(discharge_en & bat_present))
		&& !(|(~discharge_en & st_r.flag_cache & bat_present))
		|=> !st_r.active)
		else $error("removed pack did not end the run");
	AST_ALARM_END: assert property (@(posedge mclk) disable iff (sys_rst)
		st_r.active && (|(discharge_en & (stop_discharge_alarm | empty_alarm))) |=> !st_r.active)
		else $error("battery alarm did not end the run");
	AST_HOST_CLEAR: assert property (@(posedge mclk) disable iff (sys_rst)
		st_r.active && active_wr && !active_wdata |=> !st_r.active)
		else $error("host clear did not end the run");
	AST_CHARGE_AFTER: assert property (@(posedge mclk) disable iff (sys_rst)
		$fell(st_r.active) |=> charge_request)
		else $error("no charge request after the run");
	AST_REQ_PULSE: assert property (@(posedge mclk) disable iff (sys_rst)
		charge_request |=> !charge_request)
		else $error("charge request longer than one cycle");
	AST_ALERT_DRV: assert property (@(posedge mclk) disable iff (sys_rst)
		mode == MODE_STANDALONE && bat_charging[0] |=> !alert_oe_n && !alert_o)
		else $error("battery 1 charging not shown low");
	AST_ALERT_ABSENT: assert property (@(posedge mclk) disable iff (sys_rst)
		mode == MODE_STANDALONE && !bat_charging[0] && !(adapter_detected && bat_present[0])
		|=> alert_o)
		else $error("battery 1 absent not shown high");
	AST_DATA_ABSENT: assert property (@(posedge mclk) disable iff (sys_rst)
		mode == MODE_STANDALONE && !bat_charging[1] && !(adapter_detected && bat_present[1])
		|=> host_data_o)
		else $error("battery 2 absent not shown high");
	AST_DATA_BLINK: assert property (@(posedge mclk) disable iff (sys_rst)
		mode == MODE_STANDALONE && !bat_charging[1] && adapter_detected && bat_present[1]
		|=> host_data_o == ($past(st_r.blink) ^ $past(blink_edge)))
		else $error("battery 2 charge-complete blink wrong");
	AST_BLINK_TOGGLE: assert property (@(posedge mclk) disable iff (sys_rst)
		blink_edge |=> st_r.blink != $past(st_r.blink))
		else $error("blink did not toggle on a rate edge");
	AST_NO_EDGE: assert property (@(posedge mclk) disable iff (sys_rst)
		!blink_edge |=> $stable(st_r.blink))
		else $error("blink moved without a rate edge");
	AST_PIN_RELEASE: assert property (@(posedge mclk) disable iff (sys_rst)
		mode != MODE_STANDALONE |=> host_data_oe_n && alert_oe_n)
		else $error("status pins driven outside standalone");
	AST_IGNORE: assert property (@(posedge mclk) disable iff (sys_rst)
		mode == MODE_AUTONOMOUS |-> host_pins_ignored && charge_allowed)
		else $error("autonomous mode not reported");
	AST_HOST_MODE: assert property (@(posedge mclk) disable iff (sys_rst)
		mode == MODE_HOST |-> charge_allowed && !charge_blocked && !host_pins_ignored)
		else $error("host mode not reported");
	AST_SYNC: assert property (@(posedge mclk) disable iff (sys_rst)
		1'b1 |=> st_r.mode_s2 == $past(st_r.mode_s1))
		else $error("mode sense skipped a synchroniser stage");
endmodule

// ==== tb/bcmc_far_side.sv ====
// Far-side model: host clock pin used as the status blink-rate source
`timescale 1ns/100ps
module bcmc_far_side
(
	input  wire logic run,
	output logic      blink_clk
);
	// ****************************************************
	// Rate clock
	// ****************************************************
	// Pin rests high between bursts, which is how a host removes blinking
	// Odd start offset keeps its edges clear of the system clock edges
	initial
	begin
		blink_clk = 1'b1;
		#3;
		forever #24 if (run || !blink_clk) blink_clk = ~blink_clk;
	end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the conditioning and mode control block
`timescale 1ns/100ps
module testbench;
	import bcmc_pkg::*;
	logic       mclk = 1'b0;
	logic       sys_rst = 1'b1;
	// Rate clock runs through reset so the link-side toggle is cleared
	logic       run = 1'b1;
	logic       sel_wr = 1'b0;
	logic       active_wr = 1'b0;
	logic       active_wdata = 1'b0;
	logic       adapter = 1'b1;
	logic       fault = 1'b0;
	logic       strap = 1'b1;
	logic       sense = 1'b1;
	logic [3:0] sel_wdata = 4'h0;
	logic [1:0] flag = 2'h0;
	logic [1:0] pres = 2'h3;
	logic [1:0] stop_al = 2'h0;
	logic [1:0] empty_al = 2'h0;
	logic [1:0] chg = 2'h0;
	logic       blink_clk, act, pend, creq, blk, alw, ign, hd, hd_n, al, al_n, ph, pa;
	logic [1:0] dis;
	logic [3:0] sel, pwr;
	int         num_errors = 0;
	int         tests_run = 0;
	int         nreq, cyc, tg_h, tg_a;
	bcmc_far_side bcmc_far_side_inst (.run(run), .blink_clk(blink_clk));
	bcmc_core bcmc_core_inst (.mclk(mclk), .sys_rst(sys_rst), .blink_clk(blink_clk),
		.sel_wr(sel_wr), .sel_wdata(sel_wdata), .active_wr(active_wr),
		.active_wdata(active_wdata), .cond_flag(flag), .bat_present(pres),
		.stop_discharge_alarm(stop_al), .empty_alarm(empty_al), .bat_charging(chg),
		.adapter_detected(adapter), .power_fault(fault), .mode_strap(strap),
		.host_bus_supply_sense(sense), .conditioning_battery_select(sel),
		.cond_active(act), .cond_pending(pend), .discharge_en(dis), .powered_by(pwr),
		.charge_request(creq), .charge_blocked(blk), .charge_allowed(alw),
		.host_pins_ignored(ign), .host_data_o(hd), .host_data_oe_n(hd_n),
		.alert_o(al), .alert_oe_n(al_n));
	always #50 mclk = ~mclk;
	// ****************************************************
	// Shared tasks
	// ****************************************************
	task print_verdict();
		if (num_errors == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			num_errors++;
			print_verdict();
		end
	end
	task check(input string what, input logic [3:0] seen, input logic [3:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
			num_errors++;
		end
	endtask
	task step(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task wr_sel(input logic [3:0] v);
		sel_wdata = v;
		sel_wr = 1'b1;
		step(1);
		sel_wr = 1'b0;
		step(2);
	endtask
	// Counts charge requests seen in the few cycles after the write
	task wr_act(input logic v);
		active_wdata = v;
		active_wr = 1'b1;
		step(1);
		active_wr = 1'b0;
		nreq = 0;
		repeat (4)
		begin
			step(1);
			nreq += (creq === 1'b1);
		end
	endtask
	// ****************************************************
	// Scenarios
	// ****************************************************
	task t_select();
		check("select_rst", sel, SEL_RST);
		flag = 2'h1;
		step(2);
		check("pending", pend, 4'h1);
		wr_sel(SEL_BAT2);
		check("sel_refused", sel, SEL_AUTO);
		wr_sel(SEL_BAT1);
		check("sel_bat1", sel, SEL_BAT1);
		flag = 2'h3;
		step(2);
		wr_sel(SEL_BAT2);
		check("sel_bat2", sel, SEL_BAT2);
		wr_act(1'b1);
		check("disch_sel", dis, 4'h2);
		check("powered_by", pwr, PWR_BAT2);
		wr_sel(SEL_BAT1);
		check("sel_locked", sel, SEL_BAT2);
		wr_act(1'b0);
		check("active_off", act, 4'h0);
		check("charge_req", nreq[3:0], 4'h1);
		wr_sel(SEL_AUTO);
		check("sel_auto", sel, SEL_AUTO);
	endtask
	task t_auto();
		wr_act(1'b1);
		check("auto_both", dis, 4'h1);
		flag = 2'h0;
		step(3);
		check("frozen", act, 4'h1);
		pres = 2'h2;
		step(3);
		check("handover", dis, 4'h2);
		wr_act(1'b0);
		pres = 2'h3;
		step(3);
		check("none_pend", pend, 4'h0);
		wr_act(1'b1);
		check("no_start", act, 4'h0);
		check("no_req", nreq[3:0], 4'h0);
	endtask
	task t_stop();
		for (int k = 0; k < 4; k++)
		begin
			flag = 2'h2;
			step(3);
			wr_act(1'b1);
			check("auto_one", dis, 4'h2);
			adapter = (k != 0);
			fault = (k == 1);
			stop_al = (k == 2) ? 2'h2 : 2'h0;
			empty_al = (k == 3) ? 2'h2 : 2'h0;
			step(3);
			check("stop_cause", act, 4'h0);
			{adapter, fault, stop_al, empty_al} = 6'h20;
			step(3);
		end
	endtask
	task t_modes();
		for (int m = 0; m < 4; m++)
		begin
			{strap, sense} = m[1:0];
			step(5);
			check("mode_flags", {blk, ign}, {m == 1, m == 2});
			check("data_oe_n", hd_n, m != 0);
			check("allowed", alw, m != 1);
		end
	endtask
	task t_blink();
		{strap, sense} = 2'h0;
		chg = 2'h2;
		step(5);
		check("bat2_chg", {hd, al_n}, 4'h0);
		pres = 2'h2;
		step(3);
		check("bat1_absent", al, 4'h1);
		pres = 2'h3;
		chg = 2'h0;
		for (int r = 0; r < 2; r++)
		begin
			run = r[0];
			step(4);
			{tg_h, tg_a} = 0;
			{ph, pa} = {hd, al};
			repeat (40)
			begin
				step(1);
				tg_h += (hd !== ph);
				tg_a += (al !== pa);
				{ph, pa} = {hd, al};
			end
			check("blinking", {tg_h != 0, tg_a != 0}, r ? 4'h3 : 4'h0);
		end
		run = 1'b0;
	endtask
	initial
	begin
		step(20);
		sys_rst = 1'b0;
		run = 1'b0;
		step(5);
		t_select();
		t_auto();
		t_stop();
		t_modes();
		t_blink();
		print_verdict();
	end
endmodule
